/* design/fpd_pkg.sv */
/*
  Shared constants for the fast page mode DRAM module controller: strobe
  timings of the fastest speed grade, address widths and the init figures.
  Assumes a 200 MHz controller clock; every cycle count derives from it.
*/
package fpd_pkg;
  // Clock period in picoseconds.
  localparam int unsigned CLK_PS = 5000;

  // Least times in nanoseconds, fastest grade.
  localparam int unsigned T_RC_NS  = 130;  // Random cycle time.
  localparam int unsigned T_RP_NS  = 50;   // Row strobe precharge.
  localparam int unsigned T_RAS_NS = 70;   // Row strobe pulse width.
  localparam int unsigned T_RAH_NS = 10;   // Row address hold.
  localparam int unsigned T_AR_NS  = 55;   // Column address hold from row strobe.
  localparam int unsigned T_CAS_NS = 20;   // Column strobe pulse width.
  localparam int unsigned T_CAC_NS = 20;   // Access time from column strobe.
  localparam int unsigned T_CWL_NS = 20;   // Write-enable to column strobe lead.
  localparam int unsigned T_CP_NS  = 10;   // Column strobe precharge in page mode.
  localparam int unsigned T_PC_NS  = 50;   // Page mode cycle time.
  localparam int unsigned T_CSR_NS = 10;   // Column strobe set-up for refresh.
  localparam int unsigned T_CHR_NS = 20;   // Column strobe hold for refresh.
  localparam int unsigned T_WRP_NS = 10;   // Write-enable inactive before row strobe.
  localparam int unsigned T_RPC_NS = 10;   // Row precharge to column strobe fall.
  localparam int unsigned T_CPT_NS = 35;   // Column precharge in counter test.
  // Longest times, the least power-up pause, and counts.
  localparam int unsigned T_RASP_NS = 200000;  // Row strobe low in a page burst.
  localparam int unsigned T_PWR_US  = 200;     // Power-up pause.
  localparam int unsigned T_REF_MS  = 16;      // Refresh period.
  localparam int unsigned REF_ROWS  = 1024;    // Rows per refresh period.
  localparam int unsigned INIT_RAS  = 8;       // Row strobe cycles after pause.

  // Least time rounded up to cycles, never below one.
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // Longest time rounded down to cycles.
  function automatic int unsigned cyc_max(input int unsigned ns);
    return (ns * 1000) / CLK_PS;
  endfunction : cyc_max

  localparam int unsigned C_RC   = cyc_min(T_RC_NS);
  localparam int unsigned C_RP   = cyc_min(T_RP_NS);
  localparam int unsigned C_RAS  = cyc_min(T_RAS_NS);
  localparam int unsigned C_RAH  = cyc_min(T_RAH_NS);
  localparam int unsigned C_AR   = cyc_min(T_AR_NS);
  localparam int unsigned C_CAS  = cyc_min(T_CAS_NS + T_CAC_NS);
  localparam int unsigned C_CWL  = cyc_min(T_CWL_NS);
  localparam int unsigned C_CP   = cyc_min(T_CPT_NS > T_CP_NS ? T_CPT_NS : T_CP_NS);
  localparam int unsigned C_PC   = cyc_min(T_PC_NS);
  localparam int unsigned C_CSR  = cyc_min(T_CSR_NS + T_WRP_NS);
  localparam int unsigned C_CHR  = cyc_min(T_CHR_NS);
  localparam int unsigned C_RPC  = cyc_min(T_RPC_NS);
  localparam int unsigned C_RASP = cyc_max(T_RASP_NS);
  localparam int unsigned C_PWR  = cyc_min(T_PWR_US * 1000);
  localparam int unsigned C_REFI = cyc_max((T_REF_MS * 1000000) / REF_ROWS);

  // Widths of the module pins.
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
endpackage : fpd_pkg

/* design/fpd_timer.sv */
/*
  Down-counter that paces the controller states. Loaded with a cycle count,
  it pulses done on the last cycle. Assumes one clock and the shared reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fpd_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset.
  input  wire logic         clock_in,
  input  wire logic         sys_rst_in,
  // Load and status.
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  // Remaining cycles; zero means idle.
  logic [W-1:0] cnt_q;

  // A load wins over the countdown so a state can restart its wait.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // Done while the count stands at one, the last cycle of the wait.
  assign done_out = (cnt_q == W'(1));
endmodule : fpd_timer
`default_nettype wire

/* design/fpd_ctrl.sv */
/*
  Host-side controller for an 8-bit fast page mode DRAM module. It sequences
  the power-up pause and eight wake cycles, random and page-mode read and
  early-write cycles, and column-before-row refresh on a fixed interval.
  Assumes the DRAM pins are wired straight to the ports; data lines are split
  into input, output and output enable, resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module fpd_ctrl #(
  parameter int unsigned PWR_CYC  = fpd_pkg::C_PWR,
  parameter int unsigned REFI_CYC = fpd_pkg::C_REFI,
  parameter int unsigned RASP_CYC = fpd_pkg::C_RASP
) (
  // Clock and reset.
  input  wire logic                       clock_in,
  input  wire logic                       sys_rst_in,
  // User request side.
  input  wire logic                       req_valid_in,
  input  wire logic                       req_write_in,
  input  wire logic [2*fpd_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [fpd_pkg::DATA_W-1:0] req_wdata_in,
  output logic                            req_ready_out,
  output logic                            rd_valid_out,
  output logic [fpd_pkg::DATA_W-1:0]      rd_data_out,
  output logic                            init_done_out,
  // DRAM pins.
  output logic                            ras_n_out,
  output logic                            cas_n_out,
  output logic                            we_n_out,
  output logic [fpd_pkg::ADDR_W-1:0]      addr_out,
  input  wire logic [fpd_pkg::DATA_W-1:0] dq_in,
  output logic [fpd_pkg::DATA_W-1:0]      dq_out,
  output logic                            dq_oe_out
);
  localparam int unsigned AW = fpd_pkg::ADDR_W;
  localparam int unsigned DW = fpd_pkg::DATA_W;
  localparam int unsigned TW = 24;

  // One-hot controller states.
  typedef enum logic [9:0] {
    S_PWR  = 10'h001,  // Power-up pause.
    S_IRAS = 10'h002,  // Wake cycle, row strobe low.
    S_IPRE = 10'h004,  // Wake cycle precharge.
    S_IDLE = 10'h008,  // Waiting for work.
    S_RAH  = 10'h010,  // Row strobe low, row address held.
    S_CASL = 10'h020,  // Column strobe low, access in flight.
    S_CPRE = 10'h040,  // Column precharge inside the page.
    S_RPRE = 10'h080,  // Row precharge after a cycle.
    S_RCSU = 10'h100,  // Refresh: column strobe falls first.
    S_RCHR = 10'h200   // Refresh: row strobe low.
  } fpd_state_t;

  // Registered state of the controller, apart from the timer, the data synchroniser and the kick flop.
  typedef struct packed {
    fpd_state_t    st;
    logic [3:0]    init_cnt;
    logic [TW-1:0] rasp;       // Cycles the row strobe has been low.
    logic [TW-1:0] refi;       // Cycles since the last refresh interval tick.
    logic          ref_due;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic          dq_oe;
    logic [AW-1:0] row;        // Open row of the page.
    logic [AW-1:0] col;        // Column latched when a request is taken in idle; page-mode takes drive the column straight out.
    logic          wr;         // Current access is a write.
    logic          rd_valid;
    logic [DW-1:0] rd_data;
    logic          init_done;
  } fpd_regs_t;

  fpd_regs_t     q;           // Registered state.
  fpd_regs_t     d;           // Next state.
  logic          t_load;      // Restart the state timer.
  logic [TW-1:0] t_count;     // Cycles for the state timer.
  logic          t_done;      // Last cycle of the wait.
  logic [DW-1:0] dq_s1_q;     // First data synchroniser stage.
  logic [DW-1:0] dq_s2_q;     // Second data synchroniser stage.
  logic          same_row;    // Request hits the open row.
  logic          take;        // Request accepted this cycle.
  logic          pwr_kick_q;  // First cycle after reset; starts the pause.

  fpd_timer #(.W(TW)) u_timer (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (t_load),
    .count_in   (t_count),
    .done_out   (t_done)
  );

  // Read data crosses from the pins through two flops; the access window
  // is stretched to cover the two cycles of synchroniser latency.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  assign same_row = (req_addr_in[2*AW-1:AW] == q.row);
  // Requests wait while refresh is due so the 16 ms budget holds.
  assign take = req_valid_in && req_ready_out;
  assign req_ready_out = q.init_done && !q.ref_due &&
                         ((q.st == S_IDLE) || ((q.st == S_CPRE) && t_done && same_row &&
                          (q.rasp < TW'(RASP_CYC - fpd_pkg::C_PC))));

  // Next-state logic for the whole controller.
  always_comb begin
    d = q;
    t_load = 1'b0;
    t_count = '0;
    d.rd_valid = 1'b0;
    d.rasp = q.ras_n ? '0 : q.rasp + TW'(1);
    // Refresh interval counter, one row per interval.
    if (q.refi >= TW'(REFI_CYC - 1)) begin
      d.refi = '0;
      d.ref_due = q.init_done;
    end else begin
      d.refi = q.refi + TW'(1);
    end
    case (q.st)
      S_PWR: begin
        // The timer idles out of reset, so the first cycle loads the pause.
        if (pwr_kick_q) begin
          t_load = 1'b1;
          t_count = TW'(PWR_CYC);
        end else if (t_done) begin
          d.st = S_IRAS;
          d.ras_n = 1'b0;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_RAS);
        end
      end
      S_IRAS: begin
        if (t_done) begin
          d.st = S_IPRE;
          d.ras_n = 1'b1;
          d.init_cnt = q.init_cnt + 4'h1;
          t_load = 1'b1;
          // Precharge pads each wake cycle out to the random cycle time.
          t_count = TW'(fpd_pkg::C_RC - fpd_pkg::C_RAS);
        end
      end
      S_IPRE: begin
        if (t_done) begin
          if (q.init_cnt == 4'(fpd_pkg::INIT_RAS)) begin
            d.st = S_IDLE;
            d.init_done = 1'b1;
          end else begin
            d.st = S_IRAS;
            d.ras_n = 1'b0;
            t_load = 1'b1;
            t_count = TW'(fpd_pkg::C_RAS);
          end
        end
      end
      S_IDLE: begin
        if (q.ref_due) begin
          // Write-enable is already high; column strobe leads the row.
          d.st = S_RCSU;
          d.cas_n = 1'b0;
          d.we_n = 1'b1;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_CSR);
        end else if (take) begin
          d.st = S_RAH;
          d.ras_n = 1'b0;
          d.row = req_addr_in[2*AW-1:AW];
          d.col = req_addr_in[AW-1:0];
          d.addr = req_addr_in[2*AW-1:AW];
          d.wr = req_write_in;
          d.we_n = !req_write_in;
          d.dq = req_wdata_in;
          d.dq_oe = req_write_in;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_RAH);
        end
      end
      S_RAH: begin
        if (t_done) begin
          // Column strobe falls on the same edge that puts out the column address,
          // so only the column access time governs the read.
          d.st = S_CASL;
          d.addr = q.col;
          d.cas_n = 1'b0;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_CAS + 2);
        end
      end
      S_CASL: begin
        if (t_done) begin
          // Strobe stays low long enough for write-enable lead and the
          // column address hold from the row strobe.
          d.st = S_CPRE;
          d.cas_n = 1'b1;
          d.rd_valid = !q.wr;
          d.rd_data = dq_s2_q;
          d.dq_oe = 1'b0;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_CP);
        end
      end
      S_CPRE: begin
        if (take) begin
          // Next column of the open page; row strobe stays low.
          d.st = S_CASL;
          d.addr = req_addr_in[AW-1:0];
          d.cas_n = 1'b0;
          d.wr = req_write_in;
          d.we_n = !req_write_in;
          d.dq = req_wdata_in;
          d.dq_oe = req_write_in;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_CAS + 2);
        end else if (t_done) begin
          d.st = S_RPRE;
          d.ras_n = 1'b1;
          d.we_n = 1'b1;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_RC);
        end
      end
      S_RCSU: begin
        if (t_done) begin
          d.st = S_RCHR;
          d.ras_n = 1'b0;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_RAS);
        end
      end
      S_RCHR: begin
        if (t_done) begin
          d.st = S_RPRE;
          d.ras_n = 1'b1;
          d.cas_n = 1'b1;
          d.ref_due = 1'b0;
          t_load = 1'b1;
          t_count = TW'(fpd_pkg::C_RP + fpd_pkg::C_RPC);
        end
      end
      S_RPRE: begin
        if (t_done) begin
          d.st = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    // A pending interval tick after init always keeps refresh due (set wins).
    if (q.refi >= TW'(REFI_CYC - 1) && q.init_done) begin
      d.ref_due = 1'b1;
    end
  end

  // Register the whole state; reset enters the power pause, whose timer loads on the first cycle after.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{st: S_PWR, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // Kick the power-up pause one cycle after reset release.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwr_kick_q <= 1'b1;
    end else begin
      pwr_kick_q <= 1'b0;
    end
  end

  assign ras_n_out     = q.ras_n;
  assign cas_n_out     = q.cas_n;
  assign we_n_out      = q.we_n;
  assign addr_out      = q.addr;
  assign dq_out        = q.dq;
  assign dq_oe_out     = q.dq_oe;
  assign rd_valid_out  = q.rd_valid;
  assign rd_data_out   = q.rd_data;
  assign init_done_out = q.init_done;

  // Assertions.
  a_early_write_oe: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(cas_n_out) && !we_n_out |-> dq_oe_out) else $error("write data not driven");
  a_read_we_high: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !cas_n_out && !q.wr && !ras_n_out |-> we_n_out) else $error("write-enable low in read");
  a_cas_width: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(cas_n_out) && !ras_n_out |-> !cas_n_out [*4]) else $error("column strobe too short");
  a_row_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(ras_n_out) && cas_n_out |-> ##1 $stable(addr_out)) else $error("row address not held");
  a_cas_pre: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(cas_n_out) && !ras_n_out |-> cas_n_out [*7]) else $error("column precharge short");
  a_cbr_lead: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(cas_n_out) && ras_n_out |-> cas_n_out == 1'b0 [*4] ##0 ras_n_out) else $error("refresh lead short");
  a_cbr_we: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !cas_n_out && $fell(ras_n_out) |-> we_n_out && $past(we_n_out, 2)) else $error("write-enable low at refresh");
  a_ras_recover: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(ras_n_out) |-> cas_n_out [*2]) else $error("column fell after row rose");
  a_rasp_bound: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    q.rasp <= TW'(RASP_CYC)) else $error("row strobe low too long");
  a_init_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !init_done_out |-> cas_n_out && !req_ready_out) else $error("access before init");
  c_read: cover property (@(posedge clock_in) disable iff (sys_rst_in) rd_valid_out);
  c_write: cover property (@(posedge clock_in) disable iff (sys_rst_in) $fell(cas_n_out) && dq_oe_out);
  c_page: cover property (@(posedge clock_in) disable iff (sys_rst_in) q.st == S_CPRE && take);
  c_refresh: cover property (@(posedge clock_in) disable iff (sys_rst_in) q.st == S_RCHR);
endmodule : fpd_ctrl
`default_nettype wire

/* bench/fpd_dram_model.sv */
/*
  Behavioural model of the 8-bit fast page DRAM module, seen at its pins.
  Assumes 1 ns time units and that the bench resolves the shared data lines.
*/
`timescale 1ns/1ps
`default_nettype none
module fpd_dram_model #(
  parameter real PAUSE_NS = 200000.0
) (
  // Strobes and address from the controller.
  input  wire logic [fpd_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                       ras_n_in,
  input  wire logic                       cas_n_in,
  input  wire logic                       we_n_in,
  // Controller data and its enable.
  input  wire logic [7:0]                 dq_wr_in,
  input  wire logic                       dq_oe_in,
  // Data the module puts on the lines, and its tallies.
  output logic      [7:0]                 dq_out,
  output logic      [15:0]                ras_cnt_out,
  output logic      [15:0]                cbr_cnt_out,
  output logic      [15:0]                page_cnt_out,
  output logic      [15:0]                err_cnt_out
);
  logic [7:0]  mem_q [logic [21:0]];  // Eight one-bit devices side by side.
  logic [10:0] row_q;                 // Row latched at the row strobe.
  logic [7:0]  rd_q;                  // Last byte put out.
  logic        rd_en_q;               // High while the outputs drive.
  logic        wr_q;                  // High during a write column cycle.
  logic        cbr_q;                 // High during a refresh by internal counter.
  int          col_n;                 // Column cycles since the row strobe fell.
  realtime     t_rf = -1.0e6, t_rr = -1.0e6, t_cf = -1.0e6, t_cr = -1.0e6, t_wf = -1.0e6;
  initial begin
    {ras_cnt_out, cbr_cnt_out, page_cnt_out, err_cnt_out} = '0;
    {rd_q, rd_en_q, wr_q, cbr_q, row_q} = '0;
    col_n = 0;
  end
  // Released lines show the inverse of the last byte, so stale data never matches.
  assign dq_out = rd_en_q ? rd_q : ~rd_q;
  task automatic flag(input string msg);
    err_cnt_out++;
    $display("MISMATCH %0t model: %s", $time, msg);
  endtask : flag
  always @(negedge we_n_in) t_wf = $realtime;
  // Row strobe falls: a row access, or a refresh when the column strobe leads.
  always @(negedge ras_n_in) begin
    // Address and strobe change in one time step; let the pins settle first.
    #0;
    if ($realtime < PAUSE_NS) flag("row strobe inside the power-up pause");
    if ($realtime - t_rf < fpd_pkg::T_RC_NS) flag("row cycles too close");
    if ($realtime - t_rr < fpd_pkg::T_RP_NS) flag("row precharge too short");
    if (cas_n_in === 1'b0) begin
      if ($realtime - t_cf < fpd_pkg::T_CSR_NS) flag("column lead too short");
      if (we_n_in !== 1'b1) flag("write enable active at refresh");
      cbr_q = 1'b1;
      cbr_cnt_out++;
    end else begin
      row_q = addr_in;
    end
    t_rf = $realtime;
    ras_cnt_out++;
    col_n = 0;
  end
  always @(posedge ras_n_in) begin
    t_rr = $realtime;
    cbr_q = 1'b0;
  end
  // Column strobe falls: a read or an early write inside an open row.
  always @(negedge cas_n_in) begin
    // Column address, write-enable and data move with the strobe; settle first.
    #0;
    if (ras_n_in === 1'b1 && $realtime - t_rr < fpd_pkg::T_RPC_NS) flag("column fall after row rise");
    if ($realtime - t_cr < fpd_pkg::T_CP_NS) flag("column precharge too short");
    if (ras_n_in === 1'b0 && col_n > 0 && $realtime - t_cf < fpd_pkg::T_PC_NS) flag("page cycle short");
    t_cf = $realtime;
    if (ras_n_in === 1'b0) begin
      if (ras_cnt_out < fpd_pkg::INIT_RAS) flag("access before wake cycles");
      if (col_n > 0) page_cnt_out++;
      col_n++;
      wr_q = (we_n_in === 1'b0);
      if (wr_q) begin
        // Early write: data taken at this edge, outputs stay off.
        if (dq_oe_in !== 1'b1) flag("write data not driven");
        mem_q[{row_q, addr_in}] = dq_wr_in;
      end else begin
        // Column access time governs, row timing is relaxed.
        rd_q <= #(fpd_pkg::T_CAC_NS) mem_q.exists({row_q, addr_in}) ? mem_q[{row_q, addr_in}] : 8'h00;
        rd_en_q <= #(fpd_pkg::T_CAC_NS) 1'b1;
      end
    end
  end
  // Column strobe rises: outputs turn off, read and write holds are judged.
  always @(posedge cas_n_in) begin
    if (ras_n_in === 1'b0 && !wr_q && !cbr_q && we_n_in !== 1'b1) flag("write enable in read");
    if (ras_n_in === 1'b0 && wr_q && $realtime - t_wf < fpd_pkg::T_CWL_NS) flag("late write enable");
    if (cbr_q && $realtime - t_rf < fpd_pkg::T_CHR_NS) flag("refresh column hold short");
    t_cr = $realtime;
    rd_en_q = 1'b0;
    wr_q = 1'b0;
  end
  always @(posedge dq_oe_in) if (rd_en_q) flag("both sides drive data");
endmodule : fpd_dram_model
`default_nettype wire

/* bench/fpd_ctrl_bench.sv */
/*
  Self-checking bench for the DRAM module controller with a pin-level module model.
  Assumes shortened pause and refresh counts; data lines are resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
module fpd_ctrl_bench;
  localparam int unsigned PWR  = 50;   // Shortened power-up pause.
  localparam int unsigned REFI = 200;  // Shortened refresh interval.
  logic        clock_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [21:0] req_addr_in = 22'h000000;
  logic [7:0]  req_wdata_in = 8'h00;
  logic        req_ready_out, rd_valid_out, init_done_out, ras_n_out, cas_n_out, we_n_out, dq_oe_out;
  logic [7:0]  rd_data_out, dq_out, mdl_dq;
  logic [10:0] addr_out;
  logic [15:0] ras_cnt, cbr_cnt, page_cnt, err_cnt;
  wire  [7:0]  dq_in = dq_oe_out ? dq_out : mdl_dq;  // Controller wins only while it drives.
  int          miscompares = 0, checks_done = 0;
  logic [21:0] tbl_a [4] = '{22'h000000, 22'h3fffff, 22'h2aa555, 22'h0007ff};
  logic [7:0]  tbl_d [4] = '{8'h5a, 8'hff, 8'h00, 8'ha5};
  always #2.5 clock_in = ~clock_in;
  fpd_ctrl #(.PWR_CYC(PWR), .REFI_CYC(REFI), .RASP_CYC(100)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .init_done_out(init_done_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out),
    .addr_out(addr_out), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
  fpd_dram_model #(.PAUSE_NS(PWR * 5.0)) model (
    .addr_in(addr_out), .ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out),
    .dq_wr_in(dq_out), .dq_oe_in(dq_oe_out), .dq_out(mdl_dq), .ras_cnt_out(ras_cnt),
    .cbr_cnt_out(cbr_cnt), .page_cnt_out(page_cnt), .err_cnt_out(err_cnt));
  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t read byte %h, expected %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_flag(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check_flag
  // Offers a request from a rising edge and returns at the edge that takes it.
  task automatic issue(input logic wr, input logic [21:0] a, input logic [7:0] d);
    int n;
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in  <= a;
    req_wdata_in <= d;
    for (n = 0; n < 1000; n++) begin
      @(negedge clock_in);
      if (req_ready_out === 1'b1) break;
    end
    if (n == 1000) check_flag(1'b0, 1'b1, "request never taken");
    @(posedge clock_in);
  endtask : issue
  task automatic write_one(input logic [21:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    req_valid_in <= 1'b0;
    @(posedge clock_in);
  endtask : write_one
  task automatic read_back(input logic [21:0] a, input logic [7:0] exp);
    int n;
    issue(1'b0, a, 8'h00);
    req_valid_in <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(negedge clock_in);
      if (rd_valid_out === 1'b1) break;
    end
    check_flag(rd_valid_out, 1'b1, "read data never valid");
    check_data(rd_data_out, exp);
    @(posedge clock_in);
  endtask : read_back
  // A write waits from reset; nothing is taken before the pause and wake cycles.
  task automatic test_init;
    int n;
    int early;
    early = 0;
    req_valid_in <= 1'b1;
    req_write_in <= 1'b1;
    req_addr_in  <= tbl_a[0];
    req_wdata_in <= tbl_d[0];
    for (n = 0; n < 5000 && init_done_out !== 1'b1; n++) begin
      @(negedge clock_in);
      if (req_ready_out !== 1'b0 && init_done_out !== 1'b1) early++;
    end
    check_flag(early == 0, 1'b1, "request offered before init");
    check_flag(n >= PWR, 1'b1, "init ended inside the pause");
    check_flag(ras_cnt >= 16'h0008, 1'b1, "too few wake cycles");
    check_flag(req_ready_out, 1'b1, "not ready after init");
    // The pending write is taken at this edge.
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    @(posedge clock_in);
    $display("test_init finished");
  endtask : test_init
  // Boundary and alternating-bit rows and columns written, then all read back.
  task automatic test_rw;
    for (int i = 1; i < 4; i++) write_one(tbl_a[i], tbl_d[i]);
    for (int i = 0; i < 4; i++) read_back(tbl_a[i], tbl_d[i]);
    $display("test_rw finished");
  endtask : test_rw
  // Two same-row writes offered back to back chain in page mode.
  task automatic test_page;
    logic [15:0] p0;
    p0 = page_cnt;
    issue(1'b1, {11'h123, 11'h001}, 8'h11);
    issue(1'b1, {11'h123, 11'h002}, 8'h22);
    req_valid_in <= 1'b0;
    @(posedge clock_in);
    check_flag(page_cnt > p0, 1'b1, "no page-mode column cycle");
    read_back({11'h123, 11'h001}, 8'h11);
    read_back({11'h123, 11'h002}, 8'h22);
    $display("test_page finished");
  endtask : test_page
  // Idle span: refresh must keep coming, and data must survive it.
  task automatic test_refresh;
    logic [15:0] c0;
    c0 = cbr_cnt;
    repeat (3 * REFI) @(posedge clock_in);
    check_flag(cbr_cnt >= c0 + 16'h0002, 1'b1, "refresh not issued");
    read_back(tbl_a[1], tbl_d[1]);
    check_flag(err_cnt == 16'h0000, 1'b1, "model saw a timing fault");
    $display("test_refresh finished");
  endtask : test_refresh
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    test_init();
    test_rw();
    test_page();
    test_refresh();
    print_verdict();
  end
  // Whole run is under two thousand cycles; this bound cuts a hang short.
  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : fpd_ctrl_bench
`default_nettype wire
